// file: hw/fcl_pkg.sv
package fcl_pkg;
  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_RAM_LAST = 8'h1f;
  localparam logic [7:0] IDX_TEMP_LOW = 8'h60;
  localparam logic [7:0] IDX_TEMP_HIGH = 8'h61;
  localparam logic [7:0] IDX_FLASH_CMD = 8'h62;
  localparam logic [7:0] IDX_CLEAR = 8'h63;
  localparam logic [7:0] IDX_MODE_WAKE = 8'h64;
  localparam logic [7:0] IDX_PROG_DATA = 8'h6f;
  localparam logic [7:0] IDX_PROG_ADDR = 8'h70;
  localparam logic [7:0] IDX_FLASH_BASE = 8'h80;
  localparam logic [7:0] IDX_FLASH_LAST = 8'hdf;
  // ==========================================================
  // command codes
  localparam logic [7:0] CMD_PROG_BYTE = 8'h0f;
  localparam logic [7:0] CMD_ERASE_P0 = 8'h40;
  localparam logic [7:0] CMD_ERASE_P1 = 8'h41;
  localparam logic [7:0] CMD_ERASE_P2 = 8'h42;
  localparam logic [7:0] CMD_RAM_TO_FLASH = 8'h45;
  localparam logic [7:0] CMD_FLASH_TO_RAM = 8'h48;
  localparam logic [7:0] CMD_POWER_DOWN = 8'hf6;
  // ==========================================================
  // fields and reset values
  localparam int CLR_DISCHARGE_BIT = 0;
  localparam int CLR_CHARGE_BIT = 1;
  localparam int WAKE_LSB = 1;
  localparam int WAKE_MSB = 3;
  localparam logic [2:0] WAKE_RESET = 3'h7;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [6:0] FLASH_BYTES = 7'h60;
  localparam logic [4:0] PAGE_LAST = 5'h1f;
  localparam logic [1:0] PAGE_0 = 2'h0;
  localparam logic [1:0] PAGE_1 = 2'h1;
  localparam logic [1:0] PAGE_2 = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PROG,
    ST_ERASE,
    ST_RAM_TO_FLASH,
    ST_FLASH_TO_RAM,
    ST_SLEEP,
    ST_DONE
  } fcl_state_type;
endpackage

// file: hw/fcl_flash_cmd.sv
// Added by the designer: the Wishbone register port.
`timescale 1ns/10ps
// ==========================================================
module fcl_flash_cmd (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] temp_kelvin_i,
  input wire logic [6:0] sense_below_i,
  input wire logic single_wire_line_i,
  output logic sleep_o,
  output logic charge_count_clear_o,
  output logic discharge_count_clear_o
);
  import fcl_pkg::*;

  // ==========================================================
  // state
  fcl_state_type state_ff, nxt_state;
  logic [4:0] idx_ff, nxt_idx;
  logic [1:0] page_ff, nxt_page;
  logic [7:0] cmd_ff, prog_addr_ff, prog_data_ff;
  logic [7:0] clr_ff, nxt_clr;
  logic [2:0] wake_ff;
  logic [15:0] temp_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic sleep_ff, chg_clr_ff, dis_clr_ff;
  logic [7:0] flash_mem [0:95];
  logic [7:0] ram_mem [0:31];

  // ==========================================================
  // pin synchronisers: 3 flops, change taken when 2nd and 3rd agree
  logic [6:0] sense_s1_ff, sense_s2_ff, sense_s3_ff, sense_ff;
  logic line_s1_ff, line_s2_ff, line_s3_ff, line_ff;

  always_ff @(posedge clk_i) begin
    sense_s1_ff <= sense_below_i;
    sense_s2_ff <= sense_s1_ff;
    sense_s3_ff <= sense_s2_ff;
    line_s1_ff <= single_wire_line_i;
    line_s2_ff <= line_s1_ff;
    line_s3_ff <= line_s2_ff;
  end

  wire logic [6:0] sense_agree = ~(sense_s2_ff ^ sense_s3_ff);
  wire logic [6:0] nxt_sense =
    (sense_agree & sense_s3_ff) | (~sense_agree & sense_ff);
  wire logic nxt_line = (line_s2_ff == line_s3_ff) ? line_s3_ff : line_ff;
  wire logic line_edge = nxt_line != line_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sense_ff <= 7'h00;
      line_ff <= 1'b1;
    end else begin
      sense_ff <= nxt_sense;
      line_ff <= nxt_line;
    end
  end

  // ==========================================================
  // bus decode
  function automatic logic [6:0] flash_index(input logic [1:0] page,
                                             input logic [4:0] off);
    flash_index = {page, off};
  endfunction

  wire logic [7:0] bus_idx = wb_adr_i[9:2];
  wire logic bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire logic bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  wire logic bus_rd = bus_req & ~wb_we_i;
  wire logic [7:0] wbyte = wb_dat_i[7:0];
  wire logic busy = cmd_ff != 8'h00;
  wire logic hit_ram = bus_idx <= IDX_RAM_LAST;
  wire logic hit_flash = (bus_idx >= IDX_FLASH_BASE) &&
                         (bus_idx <= IDX_FLASH_LAST);
  wire logic [7:0] flash_rd_idx = bus_idx - IDX_FLASH_BASE;
  // operands and ram are frozen while a command runs
  wire logic wr_cmd = bus_wr && bus_idx == IDX_FLASH_CMD && !busy;
  wire logic wr_addr = bus_wr && bus_idx == IDX_PROG_ADDR && !busy;
  wire logic wr_data = bus_wr && bus_idx == IDX_PROG_DATA && !busy;
  wire logic wr_clr = bus_wr && bus_idx == IDX_CLEAR;
  wire logic wr_mode = bus_wr && bus_idx == IDX_MODE_WAKE;
  wire logic wr_ram = bus_wr && hit_ram && !busy;

  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit_ram)
      rd_byte = ram_mem[bus_idx[4:0]];
    else if (hit_flash)
      rd_byte = flash_mem[flash_rd_idx[6:0]];
    else begin
      case (bus_idx)
        IDX_TEMP_LOW: rd_byte = temp_ff[7:0];
        IDX_TEMP_HIGH: rd_byte = temp_ff[15:8];
        IDX_FLASH_CMD: rd_byte = cmd_ff;
        IDX_CLEAR: rd_byte = clr_ff;
        IDX_MODE_WAKE: rd_byte = {4'h0, wake_ff, 1'b0};
        IDX_PROG_DATA: rd_byte = prog_data_ff;
        IDX_PROG_ADDR: rd_byte = prog_addr_ff;
        default: rd_byte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0;
      temp_ff <= 16'h0;
    end else begin
      ack_ff <= bus_req;
      rdat_ff <= bus_rd ? {24'h0, rd_byte} : 32'h0;
      temp_ff <= temp_kelvin_i;
    end
  end

  // ==========================================================
  // host-written registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog_addr_ff <= 8'h00;
      prog_data_ff <= 8'h00;
      wake_ff <= WAKE_RESET;
    end else begin
      if (wr_addr)
        prog_addr_ff <= wbyte;
      if (wr_data)
        prog_data_ff <= wbyte;
      if (wr_mode)
        wake_ff <= wbyte[WAKE_MSB:WAKE_LSB];
    end
  end

  // clear bits live one cycle; a new write wins over the self-clear
  always_comb begin
    nxt_clr = 8'h00;
    if (wr_clr) begin
      nxt_clr[CLR_CHARGE_BIT] = wbyte[CLR_CHARGE_BIT];
      nxt_clr[CLR_DISCHARGE_BIT] = wbyte[CLR_DISCHARGE_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clr_ff <= 8'h00;
      chg_clr_ff <= 1'b0;
      dis_clr_ff <= 1'b0;
    end else begin
      clr_ff <= nxt_clr;
      chg_clr_ff <= nxt_clr[CLR_CHARGE_BIT];
      dis_clr_ff <= nxt_clr[CLR_DISCHARGE_BIT];
    end
  end

  // ==========================================================
  // command sequencer
  // wake field of zero selects no level, so power down never sleeps
  wire logic wake_ok = (wake_ff != 3'h0) && sense_ff[wake_ff - 3'h1];

  always_comb begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_page = page_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_idx = 5'h00;
        if (busy) begin
          case (cmd_ff)
            CMD_PROG_BYTE: nxt_state = ST_PROG;
            CMD_ERASE_P0: begin
              nxt_state = ST_ERASE;
              nxt_page = PAGE_0;
            end
            CMD_ERASE_P1: begin
              nxt_state = ST_ERASE;
              nxt_page = PAGE_1;
            end
            CMD_ERASE_P2: begin
              nxt_state = ST_ERASE;
              nxt_page = PAGE_2;
            end
            CMD_RAM_TO_FLASH: nxt_state = ST_RAM_TO_FLASH;
            CMD_FLASH_TO_RAM: nxt_state = ST_FLASH_TO_RAM;
            CMD_POWER_DOWN: nxt_state = wake_ok ? ST_SLEEP : ST_DONE;
            default: nxt_state = ST_DONE;
          endcase
        end
      end
      ST_PROG: nxt_state = ST_DONE;
      ST_ERASE, ST_RAM_TO_FLASH, ST_FLASH_TO_RAM: begin
        nxt_idx = idx_ff + 5'h01;
        if (idx_ff == PAGE_LAST)
          nxt_state = ST_DONE;
      end
      ST_SLEEP: begin
        if (line_edge)
          nxt_state = ST_DONE;
      end
      ST_DONE: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      idx_ff <= 5'h00;
      page_ff <= PAGE_0;
      cmd_ff <= 8'h00;
      sleep_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      page_ff <= nxt_page;
      sleep_ff <= nxt_state == ST_SLEEP;
      if (state_ff == ST_DONE)
        cmd_ff <= 8'h00;
      else if (wr_cmd)
        cmd_ff <= wbyte;
    end
  end

  // ==========================================================
  // flash and ram arrays
  // programming only pulls bits low, as a real flash cell does
  wire logic [6:0] page_idx = flash_index(page_ff, idx_ff);
  wire logic [6:0] p0_idx = flash_index(PAGE_0, idx_ff);
  wire logic prog_in_range = prog_addr_ff < {1'b0, FLASH_BYTES};
  wire logic [7:0] prog_result =
    flash_mem[prog_addr_ff[6:0]] & prog_data_ff;

  always_ff @(posedge clk_i) begin
    case (state_ff)
      ST_PROG: begin
        if (prog_in_range)
          flash_mem[prog_addr_ff[6:0]] <= prog_result;
      end
      ST_ERASE: flash_mem[page_idx] <= ERASED_BYTE;
      ST_RAM_TO_FLASH:
        flash_mem[p0_idx] <= flash_mem[p0_idx] & ram_mem[idx_ff];
      default: ;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (state_ff == ST_FLASH_TO_RAM)
      ram_mem[idx_ff] <= flash_mem[p0_idx];
    else if (wr_ram)
      ram_mem[bus_idx[4:0]] <= wbyte;
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign sleep_o = sleep_ff;
  assign charge_count_clear_o = chg_clr_ff;
  assign discharge_count_clear_o = dis_clr_ff;

  // ==========================================================
  // assertions
  property p_cmd_done;
    @(posedge clk_i) disable iff (rst_i)
      (state_ff == ST_PROG) |-> ##2 (cmd_ff == 8'h00);
  endproperty
  a_cmd_done: assert property (p_cmd_done)
    else $error("command not cleared after program byte");

  property p_unknown;
    @(posedge clk_i) disable iff (rst_i)
      (state_ff == ST_IDLE && busy && cmd_ff == 8'h11)
      |=> (state_ff == ST_DONE) ##1 (cmd_ff == 8'h00);
  endproperty
  a_unknown: assert property (p_unknown)
    else $error("unknown command not dropped");

  property p_charge_clr;
    @(posedge clk_i) disable iff (rst_i)
      (wr_clr && wbyte[CLR_CHARGE_BIT]) |=> charge_count_clear_o
      ##1 (!clr_ff[CLR_CHARGE_BIT] || $past(wr_clr));
  endproperty
  a_charge_clr: assert property (p_charge_clr)
    else $error("charge clear bit misbehaves");

  property p_dis_clr;
    @(posedge clk_i) disable iff (rst_i)
      discharge_count_clear_o |-> $past(wr_clr && wbyte[CLR_DISCHARGE_BIT]);
  endproperty
  a_dis_clr: assert property (p_dis_clr)
    else $error("discharge clear without write");

  property p_prog;
    @(posedge clk_i) disable iff (rst_i)
      (state_ff == ST_PROG && prog_in_range) |=>
      (flash_mem[$past(prog_addr_ff[6:0])] == $past(prog_result));
  endproperty
  a_prog: assert property (p_prog)
    else $error("program byte wrong");

  property p_erase;
    @(posedge clk_i) disable iff (rst_i)
      (state_ff == ST_ERASE) |=> (flash_mem[$past(page_idx)] == ERASED_BYTE);
  endproperty
  a_erase: assert property (p_erase)
    else $error("erase missed a byte");

  property p_copy;
    @(posedge clk_i) disable iff (rst_i)
      (state_ff == ST_FLASH_TO_RAM) |=>
      (ram_mem[$past(idx_ff)] == flash_mem[$past(p0_idx)]);
  endproperty
  a_copy: assert property (p_copy)
    else $error("flash to ram copy wrong");

  property p_sleep_gate;
    @(posedge clk_i) disable iff (rst_i)
      (state_ff == ST_IDLE && cmd_ff == CMD_POWER_DOWN && !wake_ok)
      |=> !sleep_o ##1 !sleep_o;
  endproperty
  a_sleep_gate: assert property (p_sleep_gate)
    else $error("slept without wake condition");

  property p_sleep_hold;
    @(posedge clk_i) disable iff (rst_i)
      (state_ff == ST_SLEEP && !line_edge) |=> sleep_o;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("left sleep without line edge");

  property p_temp;
    @(posedge clk_i) disable iff (rst_i)
      (bus_rd && bus_idx == IDX_TEMP_HIGH) |=>
      (wb_dat_o[7:0] == $past(temp_ff[15:8]));
  endproperty
  a_temp: assert property (p_temp)
    else $error("temperature high byte wrong");

  c_sleep: cover property (@(posedge clk_i) disable iff (rst_i)
    sleep_o ##1 !sleep_o);
  c_erase: cover property (@(posedge clk_i) disable iff (rst_i)
    state_ff == ST_ERASE && page_ff == PAGE_2);
  c_r2f: cover property (@(posedge clk_i) disable iff (rst_i)
    state_ff == ST_RAM_TO_FLASH && idx_ff == PAGE_LAST);
endmodule

// file: testbench/fcl_front_end.sv
`timescale 1ns/10ps
// ==========================================================
// analog front end and serial line as seen by the block
module fcl_front_end (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] temp_set_i,
  input wire logic [6:0] below_set_i,
  input wire logic wake_req_i,
  output logic [15:0] temp_kelvin_o,
  output logic [6:0] sense_below_o,
  output logic line_o
);
  logic line_ff;

  // line idles high through its pull-up; a request flips it once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_ff <= 1'b1;
    end else if (wake_req_i) begin
      line_ff <= ~line_ff;
    end
  end

  assign line_o = line_ff;
  assign temp_kelvin_o = temp_set_i;
  assign sense_below_o = below_set_i;
endmodule

// file: testbench/test_flash_command_and_clear_logic.sv
`timescale 1ns/10ps
module test_flash_command_and_clear_logic;
  import fcl_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sleep_o;
  logic [9:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [15:0] temp_set, temp_k;
  logic [6:0] below_set, below;
  logic wake_req, line, cc_o, dc_o;
  logic [7:0] q;
  int errors, cmp_count, cc_n, dc_n, sleep_n;

  fcl_flash_cmd dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .temp_kelvin_i(temp_k), .sense_below_i(below),
    .single_wire_line_i(line), .sleep_o(sleep_o),
    .charge_count_clear_o(cc_o), .discharge_count_clear_o(dc_o));

  fcl_front_end u_fe (.clk_i(clk_i), .rst_i(rst_i), .temp_set_i(temp_set),
    .below_set_i(below_set), .wake_req_i(wake_req), .temp_kelvin_o(temp_k),
    .sense_below_o(below), .line_o(line));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (cc_o === 1'b1) cc_n++;
    if (dc_o === 1'b1) dc_n++;
    if (sleep_o === 1'b1) sleep_n++;
  end

  // ==========================================================
  // bus access and checking
  task automatic wb_xfer(input logic we, input logic [7:0] idx,
                         input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    r = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50) begin
      errors++;
      $display("MISMATCH t=%0t no ack", $time);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    wb_xfer(1'b1, idx, d, r);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    wb_xfer(1'b0, idx, 8'h00, r);
    chk(r, exp);
  endtask

  // poll the command register; bounded so a stuck command shows up
  task automatic wait_idle;
    logic [7:0] r;
    int n;
    n = 0;
    do begin
      wb_xfer(1'b0, IDX_FLASH_CMD, 8'h00, r);
      n++;
    end while (r !== 8'h00 && n < 100);
    chk(r, 8'h00);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #3000000;
    errors++;
    complete_run();
  end

  // ==========================================================
  // tests
  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wake_req} = 4'h0;
    wb_adr_i = 10'h000;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    temp_set = 16'h0129;
    below_set = 7'h00;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(IDX_FLASH_CMD, 8'h00);
    rd_chk(IDX_CLEAR, 8'h00);
    rd_chk(IDX_MODE_WAKE, 8'h0e);
    rd_chk(IDX_TEMP_LOW, 8'h29);
    rd_chk(IDX_TEMP_HIGH, 8'h01);
    done("reset_temp");
    wr(IDX_CLEAR, 8'h02);
    repeat (3) @(posedge clk_i);
    chk(8'(cc_n), 8'h01);
    chk(8'(dc_n), 8'h00);
    wr(IDX_CLEAR, 8'h01);
    repeat (3) @(posedge clk_i);
    chk(8'(dc_n), 8'h01);
    rd_chk(IDX_CLEAR, 8'h00);
    done("clear");
    // operand writes during a running command must be dropped
    for (int p = 0; p < 3; p++) begin
      wr(IDX_FLASH_CMD, CMD_ERASE_P0 + 8'(p));
      wr(IDX_PROG_ADDR, 8'h33);
      wait_idle();
      rd_chk(IDX_PROG_ADDR, 8'h00);
      rd_chk(IDX_FLASH_BASE + 8'(32 * p), ERASED_BYTE);
      rd_chk(IDX_FLASH_BASE + 8'(32 * p + 31), ERASED_BYTE);
    end
    done("erase");
    wr(IDX_PROG_ADDR, 8'h25);
    wr(IDX_PROG_DATA, 8'h5a);
    wr(IDX_FLASH_CMD, CMD_PROG_BYTE);
    wait_idle();
    rd_chk(IDX_FLASH_BASE + 8'h25, 8'h5a);
    rd_chk(IDX_FLASH_BASE + 8'h24, ERASED_BYTE);
    wr(IDX_PROG_DATA, 8'h0f);
    wr(IDX_FLASH_CMD, CMD_PROG_BYTE);
    wait_idle();
    rd_chk(IDX_FLASH_BASE + 8'h25, 8'h0a);
    done("program");
    wr(8'h00, 8'h3c);
    wr(IDX_RAM_LAST, 8'hc3);
    wr(IDX_FLASH_CMD, CMD_RAM_TO_FLASH);
    wait_idle();
    rd_chk(IDX_FLASH_BASE, 8'h3c);
    rd_chk(IDX_FLASH_BASE + 8'h1f, 8'hc3);
    wr(IDX_FLASH_CMD, CMD_ERASE_P0);
    wait_idle();
    wr(IDX_PROG_ADDR, 8'h01);
    wr(IDX_PROG_DATA, 8'h77);
    wr(IDX_FLASH_CMD, CMD_PROG_BYTE);
    wait_idle();
    wr(8'h01, 8'h00);
    wr(IDX_FLASH_CMD, CMD_FLASH_TO_RAM);
    wait_idle();
    rd_chk(8'h01, 8'h77);
    rd_chk(IDX_RAM_LAST, ERASED_BYTE);
    done("copy");
    wr(IDX_FLASH_CMD, 8'h11);
    wait_idle();
    rd_chk(IDX_FLASH_BASE + 8'h01, 8'h77);
    done("unknown");
    wr(IDX_FLASH_CMD, CMD_POWER_DOWN);
    wait_idle();
    chk(8'(sleep_n), 8'h00);
    below_set <= 7'h40;
    wr(IDX_MODE_WAKE, 8'h02);
    rd_chk(IDX_MODE_WAKE, 8'h02);
    wr(IDX_FLASH_CMD, CMD_POWER_DOWN);
    wait_idle();
    chk(8'(sleep_n), 8'h00);
    wr(IDX_MODE_WAKE, 8'h0e);
    // first wake is a falling line, the second a rising one
    for (int w = 0; w < 2; w++) begin
      wr(IDX_FLASH_CMD, CMD_POWER_DOWN);
      repeat (30) @(posedge clk_i);
      chk({7'h0, sleep_o}, 8'h01);
      rd_chk(IDX_FLASH_CMD, CMD_POWER_DOWN);
      @(posedge clk_i);
      wake_req <= 1'b1;
      @(posedge clk_i);
      wake_req <= 1'b0;
      wait_idle();
      chk({7'h0, sleep_o}, 8'h00);
    end
    done("sleep");
    // reset in the middle of an erase must drop the command
    wr(IDX_FLASH_CMD, CMD_ERASE_P1);
    wr(IDX_MODE_WAKE, 8'h04);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(IDX_FLASH_CMD, 8'h00);
    rd_chk(IDX_CLEAR, 8'h00);
    rd_chk(IDX_MODE_WAKE, 8'h0e);
    done("mid_reset");
    complete_run();
  end
endmodule
